// ---- drop_count_pkg.sv ----
// Purpose: shared constants and types for the queue drop statistics bank
// Assumes: APB with 32-bit data, each printed offset is a word index
// Notes: byte address equals four times the index
package drop_count_pkg;
    localparam int unsigned QUEUES = 128;
    localparam int unsigned QUEUE_W = 7;
    localparam int unsigned COUNT_W = 24;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned IDX_W = 14;
    // Word indices as printed
    localparam logic [IDX_W-1:0] REC_BASE_IDX = 14'h3000;
    localparam logic [IDX_W-1:0] REC_END_IDX = 14'h3200;
    localparam logic [1:0] WORD_HI_IDX = 2'h0;
    localparam logic [1:0] WORD_LO_IDX = 2'h2;
    localparam logic [IDX_W-1:0] CTRL_IDX = 14'h0112;
    // Field positions of the record words and the control register
    localparam int unsigned HI_LSB = 0;
    localparam int unsigned HI_W = 8;
    localparam int unsigned OVF_BIT = 8;
    localparam int unsigned CLP0_BIT = 9;
    localparam int unsigned LO_W = 16;
    localparam int unsigned COR_BIT = 12;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;

    typedef enum logic [1:0] {
        SRC_SDRAM = 2'h0,
        SRC_TX_BUFFER = 2'h1,
        SRC_PHY_FIFO = 2'h2
    } drop_source_e;

    typedef struct packed {
        logic [QUEUE_W-1:0] queue;
        logic clp0;
        drop_source_e source;
    } drop_event_s;

    typedef struct packed {
        logic clp0_flag;
        logic overflow_flag;
        logic [COUNT_W-1:0] count;
    } drop_record_s;

    localparam int unsigned REC_W = $bits(drop_record_s);
endpackage : drop_count_pkg

// ---- record_memory.sv ----
// Purpose: storage for the per-queue drop records
// Assumes: one address port shared by read and write, on one clock
// Notes: read data is registered, one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module record_memory #(
    parameter int unsigned DEPTH = 128,
    parameter int unsigned ADDR_W = 7,
    parameter int unsigned WIDTH = 26
) (
    // Clock
    input wire logic pclk,
    // Access
    input wire logic [ADDR_W-1:0] addr,
    input wire logic we,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule : record_memory
`default_nettype wire

// ---- record_update.sv ----
// Purpose: next value of one record when a cell drop is reported
// Assumes: purely combinational
// Notes: drops at the PHY FIFO leave the record untouched
`timescale 1ns/1ns
`default_nettype none
module record_update
    import drop_count_pkg::*;
(
    // Inputs
    input wire drop_event_s drop,
    input wire drop_record_s cur,
    // Result
    output var drop_record_s nxt
);
    logic counted;

    always_comb begin
        nxt = cur;
        counted = (drop.source == SRC_SDRAM) ||
                  (drop.source == SRC_TX_BUFFER);
        if (counted) begin
            nxt.count = cur.count + COUNT_ONE;
            if (cur.count == {COUNT_W{1'b1}}) begin
                nxt.overflow_flag = 1'b1;
            end
            if (drop.clp0) begin
                nxt.clp0_flag = 1'b1;
            end
        end
    end
endmodule : record_update
`default_nettype wire

// ---- queue_drop_counters.sv ----
// Purpose: bank of per-queue dropped cell records behind APB
// Assumes: drop events are synchronous to pclk, one per handshake
// Notes: records are cleared by a sweep after reset, ready low meanwhile
`timescale 1ns/1ns
`default_nettype none
module queue_drop_counters
    import drop_count_pkg::*;
#(
    parameter int unsigned NUM_QUEUES = QUEUES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drop events from the queue manager
    input wire logic drop_valid,
    input wire drop_event_s drop_event,
    output logic drop_ready
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [4:0] {
        ST_INIT = 5'h01,
        ST_IDLE = 5'h02,
        ST_EVENT = 5'h04,
        ST_BUS_ACC = 5'h08,
        ST_BUS_DONE = 5'h10
    } state_e;

    state_e state_q, state_d;
    logic [QUEUE_W-1:0] addr_q, addr_d;
    drop_event_s event_q, event_d;
    logic clear_on_read_q, clear_on_read_d;
    logic [31:0] prdata_q, prdata_d;
    logic err_q, err_d;
    logic mem_we;
    logic [QUEUE_W-1:0] mem_addr;
    drop_record_s mem_wdata, mem_rdata, upd_rec;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic [IDX_W-1:0] idx, rel;
    logic aligned, hit_rec, hit_ctrl, is_lo;
    logic [QUEUE_W-1:0] bus_queue;

    always_comb begin
        idx = paddr[ADDR_W-1:2];
        rel = idx - REC_BASE_IDX;
        aligned = (paddr[1:0] == 2'h0);
        hit_rec = aligned && (idx >= REC_BASE_IDX) && (idx < REC_END_IDX)
                  && ((rel[1:0] == WORD_HI_IDX) || (rel[1:0] == WORD_LO_IDX))
                  && (32'(rel[IDX_W-1:2]) < NUM_QUEUES);
        hit_ctrl = aligned && (idx == CTRL_IDX);
        is_lo = (rel[1:0] == WORD_LO_IDX);
        bus_queue = rel[QUEUE_W+1:2];
    end

    ////////////////////////////////////////////////////////////////////////
    record_memory #(
        .DEPTH(NUM_QUEUES),
        .ADDR_W(QUEUE_W),
        .WIDTH(REC_W)
    ) u_mem (
        .pclk(pclk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata_q(mem_rdata)
    );

    record_update u_update (
        .drop(event_q),
        .cur(mem_rdata),
        .nxt(upd_rec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: memory is shared, so bus and drops take turns
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        event_d = event_q;
        clear_on_read_d = clear_on_read_q;
        prdata_d = prdata_q;
        err_d = err_q;
        mem_we = 1'b0;
        mem_addr = addr_q;
        mem_wdata = mem_rdata;
        drop_ready = 1'b0;
        pready = 1'b0;
        case (state_q)
            ST_INIT: begin
                mem_we = 1'b1;
                mem_wdata = '0;
                addr_d = addr_q + 7'h01;
                if (32'(addr_q) == NUM_QUEUES - 1) begin
                    addr_d = '0;
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Bus first: an APB access is short, drops wait on ready
                drop_ready = !psel;
                if (psel) begin
                    err_d = !(hit_rec || hit_ctrl);
                    prdata_d = '0;
                    addr_d = bus_queue;
                    mem_addr = bus_queue;
                    state_d = hit_rec ? ST_BUS_ACC : ST_BUS_DONE;
                end else if (drop_valid) begin
                    event_d = drop_event;
                    addr_d = drop_event.queue;
                    mem_addr = drop_event.queue;
                    state_d = ST_EVENT;
                end
            end
            ST_EVENT: begin
                mem_we = 1'b1;
                mem_wdata = upd_rec;
                state_d = ST_IDLE;
            end
            ST_BUS_ACC: begin
                if (is_lo) begin
                    prdata_d = {16'h0000, mem_rdata.count[LO_W-1:0]};
                end else begin
                    prdata_d = '0;
                    prdata_d[HI_LSB +: HI_W] = mem_rdata.count[COUNT_W-1:LO_W];
                    prdata_d[OVF_BIT] = mem_rdata.overflow_flag;
                    prdata_d[CLP0_BIT] = mem_rdata.clp0_flag;
                end
                state_d = ST_BUS_DONE;
            end
            ST_BUS_DONE: begin
                // Completes only in the access phase of the master
                pready = penable;
                if (penable) begin
                    state_d = ST_IDLE;
                end
                if (penable && hit_ctrl && pwrite) begin
                    clear_on_read_d = pwdata[COR_BIT];
                end
                if (hit_ctrl && !pwrite) begin
                    prdata_d = '0;
                end
                if (penable && hit_rec && pwrite) begin
                    mem_we = 1'b1;
                    if (is_lo) begin
                        mem_wdata.count[LO_W-1:0] = pwdata[LO_W-1:0];
                    end else begin
                        mem_wdata.count[COUNT_W-1:LO_W] =
                            pwdata[HI_LSB +: HI_W];
                        mem_wdata.overflow_flag = pwdata[OVF_BIT];
                        mem_wdata.clp0_flag = pwdata[CLP0_BIT];
                    end
                end else if (penable && hit_rec && clear_on_read_q) begin
                    mem_we = 1'b1;
                    mem_wdata.overflow_flag = 1'b0;
                    mem_wdata.clp0_flag = 1'b0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Control register read shows the clear-on-read setting
    logic [31:0] ctrl_word;
    always_comb begin
        ctrl_word = '0;
        ctrl_word[COR_BIT] = clear_on_read_q;
    end

    assign prdata = (state_q == ST_BUS_DONE && hit_ctrl) ? ctrl_word
                                                         : prdata_q;
    assign pslverr = (state_q == ST_BUS_DONE) && penable && err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_INIT;
            addr_q <= '0;
            event_q <= '0;
            clear_on_read_q <= 1'b0;
            prdata_q <= '0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            event_q <= event_d;
            clear_on_read_q <= clear_on_read_d;
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end
endmodule : queue_drop_counters
`default_nettype wire

// ---- drop_count_monitor.sv ----
// Purpose: port assertions for the queue drop record bank
// Assumes: record bytes 0xC000 + 16q, low word at +8
// Notes: bound to queue_drop_counters below
`timescale 1ns/1ns
`default_nettype none
module drop_count_monitor
    import drop_count_pkg::*;
#(
    parameter int unsigned NUM_QUEUES = QUEUES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events
    input wire logic drop_valid,
    input wire logic drop_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] age_d, age_q;
    logic rdv, rec;
    assign rdv = pready && !pwrite;
    assign rec = paddr[15:11] == 5'h18 && paddr[2:0] == 3'h0;
    // Saturates so a long run never wraps back into the sweep window
    always_comb begin
        age_d = (age_q == 8'hFF) ? age_q : age_q + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= 8'h00;
        end else begin
            age_q <= age_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_take;
        drop_valid && drop_ready;
    endsequence
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_unal;
        pready && paddr[1:0] != 2'h0 |-> pslverr;
    endproperty
    a_unal: assert property (p_unal) else $error("unaligned ok");
    property p_map;
        pready && rec |-> !pslverr;
    endproperty
    a_map: assert property (p_map) else $error("record refused");
    property p_ready;
        pready |-> s_access ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready shape");
    property p_hi;
        rdv && rec && !paddr[3] |-> prdata[31:10] == 22'h0;
    endproperty
    a_hi: assert property (p_hi) else $error("word0 spare bits");
    property p_lo;
        rdv && rec && paddr[3] |-> prdata[31:16] == 16'h0;
    endproperty
    a_lo: assert property (p_lo) else $error("word1 spare bits");
    property p_ctl;
        rdv && paddr == 16'h0448 |-> prdata[31:13] == 19'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control bits");
    // Full sweep of 128 records must end before events are taken
    property p_sweep;
        drop_ready |-> age_q >= 8'h80;
    endproperty
    a_sweep: assert property (p_sweep) else $error("early events");
    property p_gap;
        s_take |=> !drop_ready;
    endproperty
    a_gap: assert property (p_gap) else $error("no event gap");
endmodule : drop_count_monitor
bind queue_drop_counters drop_count_monitor #(.NUM_QUEUES(NUM_QUEUES)) mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drop_valid(drop_valid), .drop_ready(drop_ready));
`default_nettype wire

// ---- drop_event_model.sv ----
// Purpose: queue manager stand-in offering drop events
// Assumes: go is a one-cycle pulse while idle
// Notes: released fields show junk, never the last event
`timescale 1ns/1ns
`default_nettype none
module drop_event_model
    import drop_count_pkg::*;
(
    // Clock and request
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire drop_event_s ev,
    // Handshake
    input wire logic drop_ready,
    output logic drop_valid,
    output var drop_event_s drop_event
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_valid <= 1'b0;
            drop_event <= '0;
        end else if (go) begin
            drop_valid <= 1'b1;
            drop_event <= ev;
        end else if (drop_valid && drop_ready) begin
            drop_valid <= 1'b0;
            drop_event <= ~drop_event;
        end
    end
endmodule : drop_event_model
`default_nettype wire

// ---- queue_drop_counters_test.sv ----
// Purpose: directed bench for the queue drop record bank
// Assumes: APB master waits for pready, no fixed latency
// Notes: counts and flags are set up through the bus
`timescale 1ns/1ns
`default_nettype none
module queue_drop_counters_test;
    import drop_count_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic drop_valid, drop_ready;
    drop_event_s drop_event, ev;
    int n_mismatch, cmp_count;
    localparam int WAIT_LIMIT = 300;
    queue_drop_counters uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drop_valid(drop_valid), .drop_event(drop_event),
        .drop_ready(drop_ready));
    drop_event_model qm (.pclk(pclk), .presetn(presetn), .go(go), .ev(ev),
        .drop_ready(drop_ready), .drop_valid(drop_valid),
        .drop_event(drop_event));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic apb(input logic w, input logic [15:0] a, d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Sampled at the rising edge, before the design's own update
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < WAIT_LIMIT);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : apb
    task automatic rchk(input logic [15:0] a, e);
        apb(1'b0, a, 16'h0);
        check($sformatf("rd %h", a), {16'h0, e}, rd);
    endtask : rchk
    // Waits out the handshake, then the two-edge record update
    task automatic drop(input logic [6:0] q, logic c, drop_source_e s);
        int n;
        @(posedge pclk);
        ev <= '{queue: q, clp0: c, source: s};
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (drop_valid !== 1'b0 && n < WAIT_LIMIT);
        repeat (2) @(posedge pclk);
        if (n >= WAIT_LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : drop
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, go} = 5'h0;
        paddr = '0;
        pwdata = '0;
        ev = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rchk(16'hC7F8, 16'h0);
        rchk(16'hC200, 16'h0);
        drop(7'h05, 1'b0, SRC_SDRAM);
        drop(7'h05, 1'b0, SRC_TX_BUFFER);
        drop(7'h05, 1'b1, SRC_PHY_FIFO);
        drop(7'h05, 1'b1, drop_source_e'(2'h3));
        rchk(16'hC058, 16'h2);
        rchk(16'hC050, 16'h0);
        $display("sources test done");
        apb(1'b1, 16'hC7F0, 16'hFF);
        apb(1'b1, 16'hC7F8, 16'hFFFF);
        drop(7'h7F, 1'b1, SRC_TX_BUFFER);
        rchk(16'hC7F8, 16'h0);
        rchk(16'hC7F0, 16'h300);
        rchk(16'hC7F0, 16'h300);
        apb(1'b1, 16'hC7F0, 16'h0);
        rchk(16'hC7F0, 16'h0);
        $display("overflow test done");
        drop(7'h7F, 1'b1, SRC_SDRAM);
        apb(1'b1, 16'h0448, 16'h1000);
        rchk(16'h0448, 16'h1000);
        rchk(16'hC7F0, 16'h200);
        rchk(16'hC7F0, 16'h0);
        drop(7'h7F, 1'b1, SRC_SDRAM);
        rchk(16'hC7F8, 16'h2);
        rchk(16'hC7F0, 16'h0);
        apb(1'b0, 16'hC001, 16'h0);
        check("pslverr", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("clear test done");
        tally_and_finish();
    end
endmodule : queue_drop_counters_test
`default_nettype wire
